//--- oh_term_pkg.sv
package oh_term_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_S1_VALUE = 8'h14;
  // ****************************************
  // control fields
  // ****************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TWO_R = 2;
  localparam int CTRL_WRAPPER = 3;
  localparam int CTRL_SDCC = 4;
  localparam int CTRL_LDCC = 5;
  localparam int CTRL_MUX = 6;
  localparam int CTRL_WIDTH = 7;
  localparam logic [6:0] CTRL_RESET = 7'h08;
  localparam logic [7:0] S1_RESET = 8'h00;
  localparam int IRQ_WIDTH = 4;
  localparam int IRQ_CLIENT_LOS = 0;
  localparam int IRQ_SQUELCH = 1;
  localparam int IRQ_TRUNK_BAD = 2;
  localparam int IRQ_DCC_MODE = 3;
  // ****************************************
  // frame layout and regenerated bytes
  // ****************************************
  localparam int ROWS = 9;
  localparam int COLS = 90;
  localparam int TOH_COLS = 3;
  localparam int LANES = 4;
  localparam logic [7:0] A1_VALUE = 8'hf6;
  localparam logic [7:0] A2_VALUE = 8'h28;
  localparam logic [7:0] H1_VALUE = 8'h62;
  localparam logic [7:0] H2_VALUE = 8'h0a;
  localparam logic [7:0] H3_VALUE = 8'h00;
  localparam logic [7:0] FILL_VALUE = 8'h00;

  typedef enum logic [1:0] {
    MODE_TRANSPARENT = 2'h0,
    MODE_SECTION = 2'h1,
    MODE_LINE = 2'h2
  } term_mode_type;

  typedef enum logic [3:0] {
    OH_NONE, OH_A1, OH_A2, OH_B1, OH_SDCC, OH_SEC,
    OH_H1, OH_H2, OH_H3, OH_LDCC, OH_S1, OH_LINE
  } oh_class_type;

  typedef enum logic [1:0] {
    SQ_OPEN = 2'b00,
    SQ_SHUT = 2'b01,
    SQ_RELEASE = 2'b11
  } squelch_state_type;
endpackage : oh_term_pkg

//--- frame_position.sv
`timescale 1ns/100ps
module frame_position
  import oh_term_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic valid,
  input wire logic sof,
  output oh_term_pkg::oh_class_type oh_class,
  output logic [6:0] col
);
  logic [3:0] row_cnt;
  logic [6:0] col_cnt;
  logic [3:0] row;
  logic [3:0] next_row_cnt;
  logic [6:0] next_col_cnt;

  always_comb begin
    row = sof ? 4'h0 : row_cnt;
    col = sof ? 7'h00 : col_cnt;
    next_row_cnt = row_cnt;
    next_col_cnt = col_cnt;
    if (valid) begin
      if (col == 7'(COLS - 1)) begin
        next_col_cnt = 7'h00;
        next_row_cnt = (row == 4'(ROWS - 1)) ? 4'h0 : row + 4'h1;
      end else begin
        next_col_cnt = col + 7'h01;
        next_row_cnt = row;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      row_cnt <= 4'h0;
      col_cnt <= 7'h00;
    end else if (ce) begin
      row_cnt <= next_row_cnt;
      col_cnt <= next_col_cnt;
    end
  end

  // ****************************************
  // overhead byte classification
  // ****************************************
  always_comb begin
    oh_class = OH_NONE;
    if (col < 7'(TOH_COLS)) begin
      case (row)
        4'h0: oh_class = (col == 7'h00) ? OH_A1 :
                         (col == 7'h01) ? OH_A2 : OH_SEC;
        4'h1: oh_class = (col == 7'h00) ? OH_B1 : OH_SEC;
        4'h2: oh_class = OH_SDCC;
        4'h3: oh_class = (col == 7'h00) ? OH_H1 :
                         (col == 7'h01) ? OH_H2 : OH_H3;
        4'h4: oh_class = OH_LINE;
        4'h5, 4'h6, 4'h7: oh_class = OH_LDCC;
        4'h8: oh_class = (col == 7'h00) ? OH_S1 : OH_LINE;
        default: oh_class = OH_NONE;
      endcase
    end
  end
endmodule : frame_position

//--- overhead_termination_laser_squelch.sv
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module overhead_termination_laser_squelch
  import oh_term_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic client_los,
  input wire logic [7:0] client_data [oh_term_pkg::LANES],
  input wire logic client_valid,
  input wire logic client_sof,
  input wire logic [7:0] sdcc_byte,
  input wire logic [7:0] ldcc_byte,
  output logic [7:0] trunk_data,
  output logic trunk_valid,
  output logic trunk_sof,
  output logic trunk_remote_flag,
  output logic trunk_laser_on,
  input wire logic [7:0] trunk_rx_data,
  input wire logic trunk_rx_valid,
  input wire logic trunk_rx_sof,
  input wire logic trunk_rx_remote_flag,
  input wire logic trunk_rx_invalid,
  output logic [7:0] client_out_data,
  output logic client_out_valid,
  output logic client_laser_on
);
  import oh_term_pkg::*;

  // ****************************************
  // register file
  // ****************************************
  logic [CTRL_WIDTH-1:0] ctrl;
  logic [CTRL_WIDTH-1:0] next_ctrl;
  logic [7:0] s1_value;
  logic [7:0] next_s1_value;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] next_irq_status;
  logic [IRQ_WIDTH-1:0] irq_enable;
  logic [IRQ_WIDTH-1:0] next_irq_enable;
  logic [31:0] next_reg_rdata;
  logic next_irq;
  logic [IRQ_WIDTH-1:0] irq_event;
  logic [IRQ_WIDTH-1:0] irq_clear;
  logic client_los_q;
  logic trunk_bad_q;
  term_mode_type mode;
  logic two_r;
  logic wrapper_on;
  logic mux_on;
  logic sdcc_ok;
  logic ldcc_ok;
  logic dcc_misprov;

  always_comb begin
    mode = term_mode_type'(ctrl[CTRL_MODE_LSB +: 2]);
    two_r = ctrl[CTRL_TWO_R];
    wrapper_on = ctrl[CTRL_WRAPPER];
    mux_on = ctrl[CTRL_MUX];
    // misprovisioned dcc is refused rather than inserted
    sdcc_ok = ctrl[CTRL_SDCC] && (mode != MODE_TRANSPARENT);
    ldcc_ok = ctrl[CTRL_LDCC] && (mode == MODE_LINE);
    dcc_misprov = (ctrl[CTRL_SDCC] && !sdcc_ok) ||
                  (ctrl[CTRL_LDCC] && !ldcc_ok);
  end

  squelch_state_type sq_state;
  squelch_state_type next_sq_state;

  always_comb begin
    next_ctrl = ctrl;
    next_s1_value = s1_value;
    next_irq_enable = irq_enable;
    irq_clear = '0;
    if (reg_write) begin
      case (reg_addr)
        ADDR_CTRL: next_ctrl = reg_wdata[CTRL_WIDTH-1:0];
        ADDR_IRQ_ENABLE: next_irq_enable = reg_wdata[IRQ_WIDTH-1:0];
        ADDR_IRQ_CLEAR: irq_clear = reg_wdata[IRQ_WIDTH-1:0];
        ADDR_S1_VALUE: next_s1_value = reg_wdata[7:0];
        default: next_ctrl = ctrl;
      endcase
    end
    irq_event = '0;
    irq_event[IRQ_CLIENT_LOS] = client_los && !client_los_q;
    irq_event[IRQ_SQUELCH] = (sq_state == SQ_OPEN) &&
                             (next_sq_state == SQ_SHUT);
    irq_event[IRQ_TRUNK_BAD] = trunk_rx_invalid && !trunk_bad_q;
    irq_event[IRQ_DCC_MODE] = dcc_misprov;
    // an event in the clearing cycle survives
    next_irq_status = (irq_status & ~irq_clear) | irq_event;
    next_irq = |(next_irq_status & next_irq_enable);
    next_reg_rdata = 32'h0000_0000;
    if (reg_read) begin
      case (reg_addr)
        ADDR_CTRL: next_reg_rdata = 32'(ctrl);
        ADDR_STATUS: next_reg_rdata = {27'h0, trunk_rx_invalid,
                                       (sq_state == SQ_SHUT),
                                       sq_state, client_los};
        ADDR_IRQ_STATUS: next_reg_rdata = 32'(irq_status);
        ADDR_IRQ_ENABLE: next_reg_rdata = 32'(irq_enable);
        ADDR_S1_VALUE: next_reg_rdata = 32'(s1_value);
        default: next_reg_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      s1_value <= S1_RESET;
      irq_status <= '0;
      irq_enable <= '0;
      reg_rdata <= 32'h0000_0000;
      irq <= 1'b0;
      client_los_q <= 1'b0;
      trunk_bad_q <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      s1_value <= next_s1_value;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      reg_rdata <= next_reg_rdata;
      irq <= next_irq;
      client_los_q <= client_los;
      trunk_bad_q <= trunk_rx_invalid;
    end
  end

  // ****************************************
  // trunk transmit: overhead termination
  // ****************************************
  oh_class_type oh_class;
  logic [6:0] tx_col;
  logic [1:0] lane;
  logic [1:0] next_lane;
  logic [7:0] bip_acc;
  logic [7:0] next_bip_acc;
  logic [7:0] b1_value;
  logic [7:0] next_b1_value;
  logic [7:0] src_byte;
  logic [7:0] next_trunk_data;
  logic next_remote_flag;
  logic next_trunk_laser;
  logic regen_section;
  logic regen_line;

  frame_position u_tx_pos (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .valid(client_valid),
    .sof(client_sof),
    .oh_class(oh_class),
    .col(tx_col)
  );

  always_comb begin
    // lanes interleave byte by byte in the mux variant
    src_byte = mux_on ? client_data[lane] : client_data[0];
    next_lane = lane;
    if (client_valid && mux_on) begin
      next_lane = client_sof ? 2'h1 : lane + 2'h1;
    end
    if (client_sof) begin
      src_byte = mux_on ? client_data[0] : client_data[0];
    end
    regen_section = (mode != MODE_TRANSPARENT);
    regen_line = (mode == MODE_LINE);
    next_trunk_data = src_byte;
    case (oh_class)
      OH_A1: if (regen_section || mux_on) begin
        next_trunk_data = A1_VALUE;
      end
      OH_A2: if (regen_section || mux_on) begin
        next_trunk_data = A2_VALUE;
      end
      OH_B1: if (regen_section || mux_on) begin
        next_trunk_data = b1_value;
      end
      OH_SEC: if (regen_section) next_trunk_data = FILL_VALUE;
      OH_SDCC: if (regen_section) begin
        next_trunk_data = sdcc_ok ? sdcc_byte : FILL_VALUE;
      end
      OH_H1: if (regen_line || mux_on) next_trunk_data = H1_VALUE;
      OH_H2: if (regen_line || mux_on) next_trunk_data = H2_VALUE;
      OH_H3: if (regen_line || mux_on) next_trunk_data = H3_VALUE;
      OH_S1: if (regen_line || mux_on) next_trunk_data = s1_value;
      OH_LINE: if (regen_line) next_trunk_data = FILL_VALUE;
      OH_LDCC: if (regen_line) begin
        next_trunk_data = ldcc_ok ? ldcc_byte : FILL_VALUE;
      end
      default: next_trunk_data = src_byte;
    endcase
    // parity covers the previous outgoing frame
    next_bip_acc = bip_acc;
    next_b1_value = b1_value;
    if (client_valid) begin
      if (client_sof) begin
        next_b1_value = bip_acc;
        next_bip_acc = next_trunk_data;
      end else begin
        next_bip_acc = bip_acc ^ next_trunk_data;
      end
    end
    // no overhead exists in regeneration-only mode
    next_remote_flag = client_los && wrapper_on && !two_r &&
                       (mode == MODE_TRANSPARENT);
    next_trunk_laser = !(two_r && client_los);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lane <= 2'h0;
      bip_acc <= 8'h00;
      b1_value <= 8'h00;
      trunk_data <= 8'h00;
      trunk_valid <= 1'b0;
      trunk_sof <= 1'b0;
      trunk_remote_flag <= 1'b0;
      trunk_laser_on <= 1'b1;
    end else if (ce) begin
      lane <= next_lane;
      bip_acc <= next_bip_acc;
      b1_value <= next_b1_value;
      trunk_data <= next_trunk_data;
      trunk_valid <= client_valid;
      trunk_sof <= client_sof && client_valid;
      trunk_remote_flag <= next_remote_flag;
      trunk_laser_on <= next_trunk_laser;
    end
  end

  // ****************************************
  // trunk receive: client squelch
  // ****************************************
  logic remote_seen;
  logic next_remote_seen;
  logic squelch_cause;
  logic frame_clear;
  logic [7:0] next_client_data;
  logic next_client_laser;

  always_comb begin
    next_remote_seen = remote_seen;
    // the far-end flag is sampled once per received frame
    if (trunk_rx_valid && trunk_rx_sof) begin
      next_remote_seen = trunk_rx_remote_flag && wrapper_on;
    end
    squelch_cause = trunk_rx_invalid || next_remote_seen;
    frame_clear = trunk_rx_valid && trunk_rx_sof &&
                  !trunk_rx_invalid && !next_remote_seen;
    next_sq_state = sq_state;
    case (sq_state)
      SQ_OPEN: if (squelch_cause) next_sq_state = SQ_SHUT;
      SQ_SHUT: if (frame_clear) next_sq_state = SQ_RELEASE;
      SQ_RELEASE: next_sq_state = squelch_cause ? SQ_SHUT : SQ_OPEN;
      default: next_sq_state = SQ_SHUT;
    endcase
    next_client_laser = (next_sq_state != SQ_SHUT);
    // squelched output carries no bytes at all
    next_client_data = next_client_laser ? trunk_rx_data : 8'h00;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      remote_seen <= 1'b0;
      sq_state <= SQ_OPEN;
      client_out_data <= 8'h00;
      client_out_valid <= 1'b0;
      client_laser_on <= 1'b1;
    end else if (ce) begin
      remote_seen <= next_remote_seen;
      sq_state <= next_sq_state;
      client_out_data <= next_client_data;
      client_out_valid <= trunk_rx_valid && next_client_laser;
      client_laser_on <= next_client_laser;
    end
  end
endmodule : overhead_termination_laser_squelch

//--- far_end_trunk.sv
`timescale 1ns/100ps
module far_end_trunk
  import oh_term_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic send_flag,
  input wire logic bad,
  output logic [7:0] trunk_rx_data,
  output logic trunk_rx_valid,
  output logic trunk_rx_sof,
  output logic trunk_rx_remote_flag,
  output logic trunk_rx_invalid
);
  // ****************************************
  // far-end trunk frame source
  // ****************************************
  int pos;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos <= 0;
      trunk_rx_data <= 8'h00;
      trunk_rx_valid <= 1'b0;
      trunk_rx_sof <= 1'b0;
      trunk_rx_remote_flag <= 1'b0;
      trunk_rx_invalid <= 1'b0;
    end else begin
      pos <= (pos == ROWS * COLS - 1) ? 0 : pos + 1;
      trunk_rx_valid <= 1'b1;
      trunk_rx_sof <= (pos == 0);
      // garbage while bad, so a leak shows
      trunk_rx_data <= bad ? ~trunk_rx_data : pos[7:0];
      // flag only means something at frame start
      trunk_rx_remote_flag <= (pos == 0) ? send_flag
        : ~trunk_rx_remote_flag;
      trunk_rx_invalid <= bad;
    end
  end
endmodule : far_end_trunk

//--- overhead_termination_laser_squelch_assertions.sv
`timescale 1ns/100ps
module overhead_termination_laser_squelch_assertions
  import oh_term_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic client_los,
  input wire logic [7:0] client_data [oh_term_pkg::LANES],
  input wire logic client_valid,
  input wire logic client_sof,
  input wire logic [7:0] trunk_data,
  input wire logic trunk_valid,
  input wire logic trunk_sof,
  input wire logic trunk_remote_flag,
  input wire logic trunk_laser_on,
  input wire logic trunk_rx_valid,
  input wire logic trunk_rx_sof,
  input wire logic trunk_rx_remote_flag,
  input wire logic trunk_rx_invalid,
  input wire logic [7:0] client_out_data,
  input wire logic client_out_valid,
  input wire logic client_laser_on
);
  // ****************************************
  // control shadow, tracked from bus writes
  // ****************************************
  logic [6:0] ctrl;
  logic flag_en;
  logic two_r;
  logic [7:0] lane0;
  logic rx_sof;
  assign flag_en = ctrl[CTRL_WRAPPER] && !ctrl[CTRL_TWO_R] &&
                   ctrl[1:0] == 2'h0;
  assign two_r = ctrl[CTRL_TWO_R];
  assign lane0 = client_data[0];
  assign rx_sof = trunk_rx_sof && trunk_rx_valid;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
    end else if (ce && reg_write && reg_addr == ADDR_CTRL) begin
      ctrl <= reg_wdata[6:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_remote_flag_los: assert property (
    ce |=> trunk_remote_flag == ($past(client_los) && $past(flag_en)))
    else $error("remote flag wrong");
  chk_trunk_laser_2r: assert property (
    ce |=> trunk_laser_on == !($past(client_los) && $past(two_r)))
    else $error("trunk laser wrong");
  chk_pass_transparent: assert property (
    ce && client_valid && ctrl[1:0] == 2'h0 && !ctrl[CTRL_MUX]
    |=> trunk_data == $past(lane0)) else $error("byte altered");
  chk_tx_framing: assert property (
    ce |=> trunk_valid == $past(client_valid)
    && trunk_sof == ($past(client_sof) && $past(client_valid)))
    else $error("tx framing wrong");
  chk_regen_a1: assert property (
    ce && client_valid && client_sof && ctrl[1:0] != 2'h0
    |=> trunk_data == A1_VALUE) else $error("a1 not regenerated");
  chk_invalid_squelch: assert property (
    ce && trunk_rx_invalid |=> !client_laser_on)
    else $error("invalid not squelched");
  chk_remote_squelch: assert property (
    ce && rx_sof && trunk_rx_remote_flag && flag_en |=> !client_laser_on)
    else $error("remote flag not squelched");
  chk_squelch_hold: assert property (
    ce && !client_laser_on && !rx_sof |=> !client_laser_on)
    else $error("squelch left mid-frame");
  chk_squelch_silent: assert property (
    !client_laser_on |-> client_out_data == 8'h00 && !client_out_valid)
    else $error("data while squelched");
  cover property (ce && client_los && flag_en);
  cover property (trunk_rx_invalid ##1 !client_laser_on);
  cover property ($rose(client_laser_on));
endmodule : overhead_termination_laser_squelch_assertions

bind overhead_termination_laser_squelch
  overhead_termination_laser_squelch_assertions u_chk (
  .clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .client_los(client_los),
  .client_data(client_data), .client_valid(client_valid),
  .client_sof(client_sof), .trunk_data(trunk_data),
  .trunk_valid(trunk_valid), .trunk_sof(trunk_sof),
  .trunk_remote_flag(trunk_remote_flag), .trunk_laser_on(trunk_laser_on),
  .trunk_rx_valid(trunk_rx_valid), .trunk_rx_sof(trunk_rx_sof),
  .trunk_rx_remote_flag(trunk_rx_remote_flag),
  .trunk_rx_invalid(trunk_rx_invalid), .client_out_data(client_out_data),
  .client_out_valid(client_out_valid), .client_laser_on(client_laser_on)
);

//--- overhead_termination_laser_squelch_test.sv
`timescale 1ns/100ps
module overhead_termination_laser_squelch_test;
  import oh_term_pkg::*;
  // ****************************************
  // stimulus, tasks and test sequence
  // ****************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic client_los = 1'b0;
  logic [7:0] client_data [LANES] = '{default: 8'h00};
  logic client_valid = 1'b0;
  logic client_sof = 1'b0;
  logic [7:0] sdcc_byte = 8'hd3;
  logic [7:0] ldcc_byte = 8'h3c;
  logic send_flag = 1'b0;
  logic bad = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] trunk_data, trunk_rx_data, client_out_data;
  logic irq, trunk_valid, trunk_sof, trunk_remote_flag, trunk_laser_on;
  logic trunk_rx_valid, trunk_rx_sof, trunk_rx_remote_flag, trunk_rx_invalid;
  logic client_out_valid, client_laser_on;
  int pos = 0;
  int err_total = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  // lanes differ so the mux interleave is visible
  always @(posedge clk) begin
    pos <= (pos == ROWS * COLS - 1) ? 0 : pos + 1;
    client_valid <= 1'b1;
    client_sof <= (pos == 0);
    for (int i = 0; i < LANES; i++) begin
      client_data[i] <= pos[7:0] ^ 8'h5a ^ 8'(i);
    end
  end
  overhead_termination_laser_squelch u_dut (.clk(clk), .reset(reset),
    .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .irq(irq), .client_los(client_los), .client_data(client_data),
    .client_valid(client_valid), .client_sof(client_sof),
    .sdcc_byte(sdcc_byte), .ldcc_byte(ldcc_byte), .trunk_data(trunk_data),
    .trunk_valid(trunk_valid), .trunk_sof(trunk_sof),
    .trunk_remote_flag(trunk_remote_flag), .trunk_laser_on(trunk_laser_on),
    .trunk_rx_data(trunk_rx_data), .trunk_rx_valid(trunk_rx_valid),
    .trunk_rx_sof(trunk_rx_sof), .trunk_rx_remote_flag(trunk_rx_remote_flag),
    .trunk_rx_invalid(trunk_rx_invalid), .client_out_data(client_out_data),
    .client_out_valid(client_out_valid), .client_laser_on(client_laser_on));
  far_end_trunk u_far (.clk(clk), .reset(reset), .send_flag(send_flag),
    .bad(bad), .trunk_rx_data(trunk_rx_data),
    .trunk_rx_valid(trunk_rx_valid), .trunk_rx_sof(trunk_rx_sof),
    .trunk_rx_remote_flag(trunk_rx_remote_flag),
    .trunk_rx_invalid(trunk_rx_invalid));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask : rd
  task automatic sof_wait(input logic rx);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while ((rx ? trunk_rx_sof : trunk_sof) !== 1'b1 && k < 2000);
  endtask : sof_wait
  task automatic tx_at(input int off, input logic [7:0] e, input string n);
    sof_wait(1'b0);
    repeat (off) @(posedge clk);
    #1 chk(n, 32'(e), 32'(trunk_data));
  endtask : tx_at
  task automatic laser_wait(input logic e, input string n);
    int k;
    k = 0;
    while (client_laser_on !== e && k < 2000) begin
      @(posedge clk);
      #1 k++;
    end
    chk(n, 32'(e), 32'(client_laser_on));
  endtask : laser_wait
  initial begin
    #1500000;
    err_total++;
    $display("watchdog expired");
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_CTRL, 32'(CTRL_RESET), "ctrl");
    rd(ADDR_S1_VALUE, 32'(S1_RESET), "s1");
    rd(ADDR_IRQ_STATUS, 32'h0, "irq_status");
    rd(8'h20, 32'h0, "unmapped");
    wr(ADDR_S1_VALUE, 32'h1a5);
    rd(ADDR_S1_VALUE, 32'ha5, "s1");
    tx_at(0, 8'h5a, "sof byte");
    tx_at(270, 8'h54, "row3 byte");
    $display("test registers and transparent done");
    client_los <= 1'b1;
    wr(ADDR_IRQ_ENABLE, 32'h1);
    #1 chk("remote flag", 32'h1, 32'(trunk_remote_flag));
    chk("irq", 32'h1, 32'(irq));
    wr(ADDR_IRQ_CLEAR, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h0, "irq_status");
    chk("irq", 32'h0, 32'(irq));
    client_los <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("remote flag", 32'h0, 32'(trunk_remote_flag));
    wr(ADDR_CTRL, 32'h0c);
    client_los <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk("trunk laser", 32'h0, 32'(trunk_laser_on));
    chk("remote flag", 32'h0, 32'(trunk_remote_flag));
    client_los <= 1'b0;
    wr(ADDR_CTRL, 32'h08);
    #1 chk("trunk laser", 32'h1, 32'(trunk_laser_on));
    $display("test client loss done");
    sof_wait(1'b1);
    bad <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("client laser", 32'h0, 32'(client_laser_on));
    chk("client data", 32'h0, 32'(client_out_data));
    bad <= 1'b0;
    repeat (9) @(posedge clk);
    #1 chk("client laser", 32'h0, 32'(client_laser_on));
    laser_wait(1'b1, "client laser");
    chk("client valid", 32'h1, 32'(client_out_valid));
    send_flag <= 1'b1;
    laser_wait(1'b0, "client laser");
    rd(ADDR_STATUS, 32'h0a, "status");
    send_flag <= 1'b0;
    laser_wait(1'b1, "client laser");
    wr(ADDR_CTRL, 32'h00);
    send_flag <= 1'b1;
    repeat (1700) @(posedge clk);
    #1 chk("client laser", 32'h1, 32'(client_laser_on));
    send_flag <= 1'b0;
    rd(ADDR_IRQ_STATUS, 32'h7, "irq_status");
    $display("test squelch done");
    wr(ADDR_CTRL, 32'h19);
    tx_at(0, A1_VALUE, "a1");
    tx_at(180, 8'hd3, "sdcc");
    tx_at(360, 8'h32, "line byte");
    wr(ADDR_CTRL, 32'h3a);
    tx_at(360, FILL_VALUE, "line byte");
    tx_at(450, 8'h3c, "ldcc");
    wr(ADDR_CTRL, 32'h29);
    wr(ADDR_IRQ_CLEAR, 32'hf);
    rd(ADDR_IRQ_STATUS, 32'h8, "irq_status");
    chk("irq", 32'h0, 32'(irq));
    tx_at(450, 8'h98, "ldcc");
    wr(ADDR_CTRL, 32'h18);
    wr(ADDR_IRQ_ENABLE, 32'h8);
    wr(ADDR_IRQ_CLEAR, 32'hf);
    #1 chk("irq", 32'h1, 32'(irq));
    wr(ADDR_CTRL, 32'h48);
    tx_at(0, A1_VALUE, "a1");
    tx_at(270, H1_VALUE, "h1");
    tx_at(720, 8'ha5, "s1");
    tx_at(5, 8'h5e, "lane 1");
    // a write while frozen must not land
    ce <= 1'b0;
    wr(ADDR_CTRL, 32'h00);
    ce <= 1'b1;
    rd(ADDR_CTRL, 32'h48, "ctrl frozen");
    $display("test modes done");
    end_sim;
  end
endmodule : overhead_termination_laser_squelch_test
